// ===== rtl/awps_top.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module awps_top
  import awps_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  input  wire logic              i_dma_valid,
  input  wire logic [15:0]       i_dma_data,
  input  wire logic              i_verify_done,
  input  wire logic              i_verify_fail,
  input  wire logic              i_offline_done,
  output logic                   o_busy,
  output logic                   o_drq,
  output logic                   o_dma_req,
  output logic                   o_intrq,
  output logic                   o_err,
  output logic                   o_media_wr,
  output logic      [31:0]       o_media_lba,
  output logic      [15:0]       o_media_data,
  output logic                   o_verify_req,
  output logic      [1:0]        o_power_mode,
  output logic                   o_smart_req,
  output logic      [7:0]        o_smart_op
);
  // ==========================================================================
  // state
  awps_state_t state_q, state_d;
  awps_class_t cls_q, cls_d, dec_cls;
  awps_pwr_t   mode_q, mode_d;
  logic        busy_q, busy_d, drq_q, drq_d, dmarq_q, dmarq_d, intrq_q, intrq_d, err_q, err_d;
  logic        smart_q, smart_d, asave_q, asave_d, offl_q, offl_d;
  logic        mult_q, mult_d, ver_q, ver_d, vreq_q, vreq_d;
  logic        mwr_q, mwr_d, sreq_q, sreq_d;
  logic [7:0]  feat_q, feat_d, multn_q, multn_d, blk_q, blk_d, bidx_q, bidx_d, sop_q, sop_d;
  logic [15:0] cnt_q, cnt_d, mdata_q, mdata_d;
  logic [31:0] lba_q, lba_d, stime_q, stime_d, rdata_q, rdata_d, mlba_q, mlba_d;
  logic        dec_ext, dec_mult, dec_ver;
  logic        go, word_ok, sec_end, finish, wload, sload;
  logic        wlast, slast;
  logic [8:0]  wcnt;
  logic [16:0] scnt;
  logic [15:0] word;
  logic [7:0]  widx;
  logic [15:0] buf_mem [256];

  awps_decode u_decode (
    .i_opcode   (i_wdata[7:0]),
    .i_feature  (feat_q),
    .i_smart_en (smart_q),
    .o_class    (dec_cls),
    .o_ext      (dec_ext),
    .o_mult     (dec_mult),
    .o_verify   (dec_ver)
  );

  awps_count #(.W(9)) u_words (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_load    (wload),
    .i_value   (WORDS_PER_SECTOR),
    .i_dec     (word_ok),
    .o_count   (wcnt),
    .o_last    (wlast)
  );

  awps_count #(.W(17)) u_sectors (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_load    (sload),
    .i_value   (awps_sectors(cnt_q, dec_ext)),
    .i_dec     (sec_end),
    .o_count   (scnt),
    .o_last    (slast)
  );

  // ==========================================================================
  // command engine and register file
  assign go      = i_wr && (i_addr == OFS_COMMAND) && (state_q == ST_IDLE);
  assign word    = dmarq_q ? i_dma_data : i_wdata[15:0];
  assign word_ok = (state_q == ST_XFER) && (dmarq_q ? i_dma_valid : (i_wr && i_addr == OFS_DATA));
  assign widx    = 8'(WORDS_PER_SECTOR - wcnt);

  always_comb begin
    state_d = state_q;  cls_d = cls_q;     mode_d = mode_q;
    busy_d  = busy_q;   drq_d = drq_q;     dmarq_d = dmarq_q;
    intrq_d = intrq_q;  err_d = err_q;     smart_d = smart_q;
    asave_d = asave_q;  offl_d = offl_q;   mult_d = mult_q;
    ver_d   = ver_q;    vreq_d = vreq_q;   feat_d = feat_q;
    multn_d = multn_q;  blk_d = blk_q;     bidx_d = bidx_q;
    cnt_d   = cnt_q;    lba_d = lba_q;     sop_d = sop_q;     mlba_d = mlba_q;
    mdata_d = mdata_q;  mwr_d = 1'b0;      sreq_d = 1'b0;
    rdata_d = 32'h0000_0000;
    wload   = 1'b0;     sload = 1'b0;      sec_end = 1'b0;
    finish  = 1'b0;
    // smart timer only runs while enabled
    stime_d = smart_q ? stime_q + 32'h0000_0001 : 32'h0000_0000;
    if (offl_q && i_offline_done) begin
      offl_d = 1'b0;
    end
    if (i_wr && state_q == ST_IDLE) begin
      case (i_addr)
        OFS_FEATURE:   feat_d  = i_wdata[7:0];
        OFS_COUNT:     cnt_d   = i_wdata[15:0];
        OFS_LBA:       lba_d   = i_wdata;
        OFS_MULTIPLE:  multn_d = i_wdata[7:0];
        OFS_BUF_INDEX: bidx_d  = i_wdata[7:0];
        default:       ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        OFS_FEATURE:    rdata_d = {24'h000000, feat_q};
        OFS_COUNT:      rdata_d = {16'h0000, cnt_q};
        OFS_LBA:        rdata_d = lba_q;
        OFS_MULTIPLE:   rdata_d = {24'h000000, multn_q};
        OFS_SMART_TIME: rdata_d = stime_q;
        OFS_BUF_INDEX:  rdata_d = {24'h000000, bidx_q};
        OFS_BUF_DATA:   rdata_d = {16'h0000, buf_mem[bidx_q]};
        OFS_STATUS: begin
          rdata_d = {22'h000000, mode_q, 1'b0, offl_q, asave_q, smart_q, intrq_q, err_q, drq_q, busy_q};
          intrq_d = 1'b0;
        end
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          cls_d = dec_cls;
          err_d = 1'b0;
          mult_d = dec_mult;
          ver_d = dec_ver;
          if (dec_cls == CL_WDMA || dec_cls == CL_WPIO || dec_cls == CL_WBUF) begin
            state_d = ST_XFER;
            mode_d  = PWR_ACTIVE;
            wload   = 1'b1;
            sload   = 1'b1;
            blk_d   = (dec_mult && multn_q != 8'h00) ? multn_q : BLOCK_ONE;
            dmarq_d = (dec_cls == CL_WDMA);
            drq_d   = (dec_cls != CL_WDMA);
          end else begin
            state_d = ST_EXEC;
            busy_d  = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
        intrq_d = 1'b1;
        case (cls_q)
          CL_SLEEP:      mode_d = PWR_SLEEP;
          CL_STANDBY:    mode_d = PWR_STANDBY;
          CL_SMART_READ: begin
            sreq_d = 1'b1;
            sop_d  = feat_q;
          end
          CL_SMART_SAVE: asave_d = (cnt_q[7:0] != 8'h00);
          CL_SMART_OFFL: offl_d  = 1'b1;
          CL_SMART_ON:   smart_d = 1'b1;
          CL_SMART_OFF: begin
            smart_d = 1'b0;
            asave_d = 1'b0;
            offl_d  = 1'b0;
            stime_d = 32'h0000_0000;
          end
          default:       err_d = 1'b1;
        endcase
      end
      ST_XFER: begin
        if (word_ok) begin
          mdata_d = word;
          mlba_d  = lba_q;
          mwr_d   = (cls_q != CL_WBUF);
          if (wlast) begin
            if (ver_q) begin
              state_d = ST_VERIFY;
              drq_d   = 1'b0;
              busy_d  = 1'b1;
              vreq_d  = 1'b1;
            end else begin
              sec_end = 1'b1;
            end
          end
        end
      end
      ST_VERIFY: begin
        if (i_verify_done) begin
          vreq_d = 1'b0;
          busy_d = 1'b0;
          if (i_verify_fail) begin
            err_d  = 1'b1;
            finish = 1'b1;
          end else begin
            sec_end = 1'b1;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (sec_end) begin
      lba_d = lba_q + 32'h0000_0001;
      if (slast || cls_q == CL_WBUF) begin
        finish = 1'b1;
      end else begin
        wload   = 1'b1;
        state_d = ST_XFER;
        drq_d   = !dmarq_q;
        if (blk_q <= BLOCK_ONE) begin
          intrq_d = !dmarq_q;
          blk_d   = (mult_q && multn_q != 8'h00) ? multn_q : BLOCK_ONE;
        end else begin
          blk_d = blk_q - BLOCK_ONE;
        end
      end
    end
    if (finish) begin
      state_d = ST_IDLE;
      drq_d   = 1'b0;
      dmarq_d = 1'b0;
      busy_d  = 1'b0;
      intrq_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;  cls_q <= CL_ABORT;  mode_q <= PWR_ACTIVE;
      busy_q  <= 1'b0;     drq_q <= 1'b0;      dmarq_q <= 1'b0;
      intrq_q <= 1'b0;     err_q <= 1'b0;      smart_q <= 1'b0;
      asave_q <= 1'b0;     offl_q <= 1'b0;     mult_q <= 1'b0;
      ver_q   <= 1'b0;     vreq_q <= 1'b0;     feat_q <= 8'h00;
      multn_q <= MULT_RESET; blk_q <= BLOCK_ONE; bidx_q <= 8'h00;
      cnt_q   <= 16'h0000; lba_q <= 32'h0000_0000; sop_q <= 8'h00;
      mdata_q <= 16'h0000; mwr_q <= 1'b0;      sreq_q <= 1'b0;  mlba_q <= 32'h0000_0000;
      stime_q <= 32'h0000_0000; rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;  cls_q <= cls_d;     mode_q <= mode_d;
      busy_q  <= busy_d;   drq_q <= drq_d;     dmarq_q <= dmarq_d;
      intrq_q <= intrq_d;  err_q <= err_d;     smart_q <= smart_d;
      asave_q <= asave_d;  offl_q <= offl_d;   mult_q <= mult_d;
      ver_q   <= ver_d;    vreq_q <= vreq_d;   feat_q <= feat_d;
      multn_q <= multn_d;  blk_q <= blk_d;     bidx_q <= bidx_d;
      cnt_q   <= cnt_d;    lba_q <= lba_d;     sop_q <= sop_d;
      mdata_q <= mdata_d;  mwr_q <= mwr_d;     sreq_q <= sreq_d;  mlba_q <= mlba_d;
      stime_q <= stime_d;  rdata_q <= rdata_d;
    end
  end

  // sector buffer, overwritten only by the buffer write command
  always_ff @(posedge i_ref_clk) begin
    if (word_ok && cls_q == CL_WBUF) begin
      buf_mem[widx] <= word;
    end
  end

  assign o_rdata      = rdata_q;
  assign o_busy       = busy_q;
  assign o_drq        = drq_q;
  assign o_dma_req    = dmarq_q;
  assign o_intrq      = intrq_q;
  assign o_err        = err_q;
  assign o_media_wr   = mwr_q;
  assign o_media_lba  = mlba_q;
  assign o_media_data = mdata_q;
  assign o_verify_req = vreq_q;
  assign o_power_mode = mode_q;
  assign o_smart_req  = sreq_q;
  assign o_smart_op   = sop_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sleep_cmd_a: assert property (go && dec_cls == CL_SLEEP |=> o_busy ##1 !o_busy && o_intrq && o_power_mode == PWR_SLEEP)
    else $error("sleep sequence wrong");
  standby_cmd_a: assert property (go && dec_cls == CL_STANDBY |=> o_busy ##1 !o_busy && o_intrq && o_power_mode == PWR_STANDBY)
    else $error("standby sequence wrong");
  smart_read_a: assert property (state_q == ST_EXEC && cls_q == CL_SMART_READ |=> o_smart_req && o_smart_op == $past(feat_q))
    else $error("smart read not issued");
  smart_offl_a: assert property (state_q == ST_EXEC && cls_q == CL_SMART_OFFL |=> offl_q && !o_err)
    else $error("offline not started");
  smart_idle_a: assert property (!smart_q && stime_q == 32'h0000_0000 && !(state_q == ST_EXEC && cls_q == CL_SMART_ON) |=> stime_q == 32'h0000_0000)
    else $error("smart timer runs while disabled");
  smart_off_a: assert property (state_q == ST_EXEC && cls_q == CL_SMART_OFF |=> !smart_q && stime_q == 32'h0000_0000 && !offl_q)
    else $error("smart disable incomplete");
  smart_abort_a: assert property (go && i_wdata[7:0] == OP_SMART && !smart_q && feat_q != FT_ENABLE |=> ##1 o_err && o_intrq && !smart_q)
    else $error("disabled smart not aborted");
  buf_write_a: assert property (word_ok && cls_q == CL_WBUF |=> !o_media_wr)
    else $error("buffer write reached media");
  dma_path_a: assert property (state_q == ST_XFER && cls_q == CL_WDMA |-> o_dma_req && !o_drq)
    else $error("dma write used pio handshake");
  zero_std_a: assert property (go && dec_cls != CL_ABORT && !dec_ext && cnt_q[7:0] == 8'h00 && sload |=> scnt == SECT_MAX_STD)
    else $error("zero count not 256");
  zero_ext_a: assert property (go && dec_ext && cnt_q == 16'h0000 |=> scnt == SECT_MAX_EXT)
    else $error("zero count not 65536");
  verify_hold_a: assert property (state_q == ST_VERIFY |-> o_verify_req && o_busy && !o_drq)
    else $error("verify phase wrong");
  abort_cmd_a: assert property (go && dec_cls == CL_ABORT |=> ##1 o_err && o_intrq && $stable(o_power_mode))
    else $error("abort not reported");
  mult_cnt_a: assert property (sec_end && !slast && mult_q && blk_q > BLOCK_ONE && !(i_rd && i_addr == OFS_STATUS) |=> $stable(o_intrq))
    else $error("multiple interrupt mid block");

  pio_done_c:   cover property (state_q == ST_XFER && cls_q == CL_WPIO && finish);
  verify_ok_c:  cover property (state_q == ST_VERIFY && i_verify_done && !i_verify_fail);
  smart_cyc_c:  cover property (state_q == ST_EXEC && cls_q == CL_SMART_ON ##[1:40] state_q == ST_EXEC && cls_q == CL_SMART_OFF);
endmodule : awps_top

// ===== rtl/awps_pkg.sv
package awps_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_FEATURE    = 8'h00;
  localparam logic [7:0]  OFS_COUNT      = 8'h04;
  localparam logic [7:0]  OFS_LBA        = 8'h08;
  localparam logic [7:0]  OFS_COMMAND    = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  localparam logic [7:0]  OFS_DATA       = 8'h14;
  localparam logic [7:0]  OFS_MULTIPLE   = 8'h18;
  localparam logic [7:0]  OFS_SMART_TIME = 8'h1c;
  localparam logic [7:0]  OFS_BUF_INDEX  = 8'h20;
  localparam logic [7:0]  OFS_BUF_DATA   = 8'h24;
  // ==========================================================================
  // status bit positions
  localparam int unsigned STB_BUSY     = 0;
  localparam int unsigned STB_DRQ      = 1;
  localparam int unsigned STB_ERR      = 2;
  localparam int unsigned STB_INTRQ    = 3;
  localparam int unsigned STB_SMART    = 4;
  localparam int unsigned STB_AUTOSAVE = 5;
  localparam int unsigned STB_OFFLINE  = 6;
  localparam int unsigned STB_MODE     = 8;
  // ==========================================================================
  // opcodes and features
  localparam logic [7:0] OP_SLEEP_A    = 8'h99;
  localparam logic [7:0] OP_SLEEP_B    = 8'he6;
  localparam logic [7:0] OP_SMART      = 8'hb0;
  localparam logic [7:0] OP_STANDBY    = 8'he2;
  localparam logic [7:0] OP_STANDBY_IM = 8'he0;
  localparam logic [7:0] OP_WR_BUFFER  = 8'he8;
  localparam logic [7:0] OP_WR_DMA_A   = 8'hca;
  localparam logic [7:0] OP_WR_DMA_B   = 8'hcb;
  localparam logic [7:0] OP_WR_DMA_EXT = 8'h35;
  localparam logic [7:0] OP_WR_MULT    = 8'hc5;
  localparam logic [7:0] OP_WR_MULT_EX = 8'h39;
  localparam logic [7:0] OP_WR_SECT    = 8'h30;
  localparam logic [7:0] OP_WR_SECT_EX = 8'h34;
  localparam logic [7:0] OP_WR_NOERASE = 8'h38;
  localparam logic [7:0] OP_WR_VERIFY  = 8'h3c;
  localparam logic [7:0] FT_READ_DATA  = 8'hd0;
  localparam logic [7:0] FT_AUTOSAVE   = 8'hd2;
  localparam logic [7:0] FT_OFFLINE    = 8'hd4;
  localparam logic [7:0] FT_READ_LOG   = 8'hd5;
  localparam logic [7:0] FT_ENABLE     = 8'hd8;
  localparam logic [7:0] FT_DISABLE    = 8'hd9;
  localparam logic [7:0] FT_STATUS     = 8'hda;
  // ==========================================================================
  // sizes and reset values
  localparam logic [8:0]  WORDS_PER_SECTOR = 9'h100;
  localparam logic [16:0] SECT_MAX_STD     = 17'h00100;
  localparam logic [16:0] SECT_MAX_EXT     = 17'h10000;
  localparam logic [7:0]  MULT_RESET       = 8'h01;
  localparam logic [7:0]  BLOCK_ONE        = 8'h01;

  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SLEEP   = 2'b10
  } awps_pwr_t;

  typedef enum logic [3:0] {
    CL_ABORT      = 4'b0000,
    CL_SLEEP      = 4'b0001,
    CL_STANDBY    = 4'b0010,
    CL_SMART_READ = 4'b0011,
    CL_SMART_SAVE = 4'b0100,
    CL_SMART_OFFL = 4'b0101,
    CL_SMART_ON   = 4'b0110,
    CL_SMART_OFF  = 4'b0111,
    CL_WBUF       = 4'b1000,
    CL_WDMA       = 4'b1001,
    CL_WPIO       = 4'b1010
  } awps_class_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_XFER   = 2'b10,
    ST_VERIFY = 2'b11
  } awps_state_t;

  function automatic logic [16:0] awps_sectors(input logic [15:0] cnt, input logic ext);
    logic [16:0] n;
    n = ext ? {1'b0, cnt} : {9'h000, cnt[7:0]};
    if (n == 17'h00000) begin
      n = ext ? SECT_MAX_EXT : SECT_MAX_STD;
    end
    return n;
  endfunction : awps_sectors
endpackage : awps_pkg

// ===== rtl/awps_count.sv
`timescale 1ns/1ps
module awps_count
  import awps_pkg::*;
#(
  parameter int unsigned W = 9
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  input  wire logic         i_dec,
  output logic      [W-1:0] o_count,
  output logic              o_last
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (i_load) begin
      cnt_d = i_value;
    end else if (i_dec && cnt_q != '0) begin
      cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_count = cnt_q;
  assign o_last  = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule : awps_count

// ===== rtl/awps_decode.sv
`timescale 1ns/1ps
module awps_decode
  import awps_pkg::*;
(
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_feature,
  input  wire logic       i_smart_en,
  output awps_class_t     o_class,
  output logic            o_ext,
  output logic            o_mult,
  output logic            o_verify
);
  always_comb begin
    o_class  = CL_ABORT;
    o_ext    = 1'b0;
    o_mult   = 1'b0;
    o_verify = 1'b0;
    case (i_opcode)
      OP_SLEEP_A, OP_SLEEP_B:     o_class = CL_SLEEP;
      OP_STANDBY, OP_STANDBY_IM:  o_class = CL_STANDBY;
      OP_WR_BUFFER:               o_class = CL_WBUF;
      OP_WR_DMA_A, OP_WR_DMA_B:   o_class = CL_WDMA;
      OP_WR_DMA_EXT: begin
        o_class = CL_WDMA;
        o_ext   = 1'b1;
      end
      OP_WR_MULT, OP_WR_MULT_EX: begin
        o_class = CL_WPIO;
        o_mult  = 1'b1;
        o_ext   = (i_opcode == OP_WR_MULT_EX);
      end
      OP_WR_SECT, OP_WR_NOERASE:  o_class = CL_WPIO;
      OP_WR_SECT_EX: begin
        o_class = CL_WPIO;
        o_ext   = 1'b1;
      end
      OP_WR_VERIFY: begin
        o_class  = CL_WPIO;
        o_verify = 1'b1;
      end
      OP_SMART: begin
        if (i_feature == FT_ENABLE) begin
          o_class = CL_SMART_ON;
        end else if (!i_smart_en) begin
          o_class = CL_ABORT;
        end else begin
          case (i_feature)
            FT_READ_DATA, FT_READ_LOG, FT_STATUS: o_class = CL_SMART_READ;
            FT_AUTOSAVE: o_class = CL_SMART_SAVE;
            FT_OFFLINE:  o_class = CL_SMART_OFFL;
            FT_DISABLE:  o_class = CL_SMART_OFF;
            default:     o_class = CL_ABORT;
          endcase
        end
      end
      default: o_class = CL_ABORT;
    endcase
  end
endmodule : awps_decode

// ===== testbench/awps_host_model.sv
`timescale 1ns/1ps
// ====
// dma word source and media verify answer
module awps_host_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_dma_req,
  input  wire logic        i_verify_req,
  input  wire logic        i_slow,
  input  wire logic        i_fail,
  input  wire logic [15:0] i_key,
  output logic             o_dma_valid,
  output logic      [15:0] o_dma_data,
  output logic             o_verify_done,
  output logic             o_verify_fail
);
  logic [15:0] n;
  logic [2:0]  t;
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      {o_dma_valid, o_dma_data, o_verify_done, o_verify_fail, n, t} <= '0;
    end else begin
      o_dma_valid <= 1'b0;
      o_dma_data <= ~o_dma_data;
      o_verify_done <= 1'b0;
      o_verify_fail <= ~o_verify_fail;
      n <= i_dma_req ? n : 16'h0000;
      t <= (t == 3'h0) ? (i_slow ? 3'h3 : 3'h1) : t - 3'h1;
      if (i_dma_req && t == 3'h0) begin
        o_dma_valid <= 1'b1;
        o_dma_data <= n ^ i_key;
        n <= n + 16'h0001;
      end
      if (i_verify_req && t == 3'h0 && !o_verify_done) begin
        o_verify_done <= 1'b1;
        o_verify_fail <= i_fail;
      end
    end
  end
endmodule : awps_host_model

// ===== testbench/awps_top_bench.sv
`timescale 1ns/1ps
module awps_top_bench;
  import awps_pkg::*;
  logic        i_ref_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_offline_done = 1'b0;
  logic        slow = 1'b0, fail = 1'b0, irq_d = 1'b0, i_dma_valid, i_verify_done, i_verify_fail;
  logic        o_busy, o_drq, o_dma_req, o_intrq, o_err, o_media_wr, o_verify_req, o_smart_req;
  logic [7:0]  i_addr = 8'h00, o_smart_op, op;
  logic [31:0] i_wdata = 32'h0, d, base = 32'h0, o_rdata, o_media_lba;
  logic [15:0] key = 16'h0, i_dma_data, o_media_data;
  logic [1:0]  o_power_mode;
  logic [7:0]  fts [3] = '{FT_READ_DATA, FT_READ_LOG, FT_STATUS};
  int          failures = 0, checks_done = 0, nw = 0, irqs = 0;
  awps_top u_dut (.*);
  awps_host_model u_host (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_dma_req(o_dma_req),
    .i_verify_req(o_verify_req), .i_slow(slow), .i_fail(fail), .i_key(key), .o_dma_valid(i_dma_valid),
    .o_dma_data(i_dma_data), .o_verify_done(i_verify_done), .o_verify_fail(i_verify_fail));
  always #12.5 i_ref_clk = ~i_ref_clk;
  // ====
  // helpers
  function automatic logic [15:0] pat(input int k);
    return k[15:0] ^ key;
  endfunction : pat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_ref_clk);
  endtask : rd
  task automatic cmd(input logic [7:0] o, input logic [7:0] f, input logic e, input logic [1:0] m);
    wr(OFS_FEATURE, {24'h0, f});
    wr(OFS_COMMAND, {24'h0, o});
    #1 chk({26'h0, o_smart_req, o_busy, o_intrq, o_err, o_power_mode},
           {26'h0, (o == OP_SMART && !e && (f inside {FT_READ_DATA, FT_READ_LOG, FT_STATUS})), 1'b0, 1'b1, e, m});
    @(posedge i_ref_clk);
    rd(OFS_STATUS);
  endtask : cmd
  task automatic wait_idle();
    repeat (3) @(posedge i_ref_clk);
    while (o_busy || o_verify_req || o_dma_req) @(posedge i_ref_clk);
    @(posedge i_ref_clk);
  endtask : wait_idle
  task automatic xfer(input logic [7:0] o, input logic [15:0] c, input int ns, ew, ei, input logic e);
    base = $urandom;
    key = $urandom;
    wr(OFS_COUNT, {16'h0, c});
    wr(OFS_LBA, base);
    nw = 0;
    irqs = 0;
    wr(OFS_COMMAND, {24'h0, o});
    for (int s = 0; s < ns; s++) begin
      i_addr <= OFS_DATA;
      i_wr <= 1'b1;
      for (int k = 0; k < 256; k++) begin
        i_wdata <= {16'h0, pat(s * 256 + k)};
        @(posedge i_ref_clk);
      end
      i_wr <= 1'b0;
      wait_idle();
      rd(OFS_STATUS);
    end
    wait_idle();
    rd(OFS_STATUS);
    chk(nw, ew);
    chk(irqs, ei);
    chk(d[2], e);
  endtask : xfer
  task automatic print_verdict();
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // ====
  // media monitor and tests
  always @(posedge i_ref_clk) begin
    irq_d <= o_intrq;
    if (o_intrq && !irq_d) irqs++;
    if (o_media_wr) begin
      chk(o_media_lba, base + 32'(nw / 256));
      chk({16'h0, o_media_data}, {16'h0, pat(nw)});
      nw++;
    end
  end
  initial begin
    repeat (95000) @(posedge i_ref_clk);
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(66653));
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    rd(OFS_SMART_TIME);
    chk(d, 32'h0);
    cmd(OP_SMART, FT_READ_DATA, 1'b1, 2'b00);
    cmd(OP_SMART, FT_DISABLE, 1'b1, 2'b00);
    cmd(OP_SMART, FT_ENABLE, 1'b0, 2'b00);
    rd(OFS_SMART_TIME);
    chk({31'h0, d != 32'h0}, 32'h1);
    foreach (fts[i]) begin
      cmd(OP_SMART, fts[i], 1'b0, 2'b00);
      chk({24'h0, o_smart_op}, {24'h0, fts[i]});
    end
    wr(OFS_COUNT, 32'h1);
    cmd(OP_SMART, FT_AUTOSAVE, 1'b0, 2'b00);
    chk(d[5], 1'b1);
    cmd(OP_SMART, FT_OFFLINE, 1'b0, 2'b00);
    chk(d[6], 1'b1);
    i_offline_done <= 1'b1;
    @(posedge i_ref_clk);
    i_offline_done <= 1'b0;
    rd(OFS_STATUS);
    chk(d[6], 1'b0);
    cmd(OP_SMART, FT_OFFLINE, 1'b0, 2'b00);
    chk(d[6], 1'b1);
    cmd(OP_SMART, 8'h11, 1'b1, 2'b00);
    cmd(OP_SMART, FT_DISABLE, 1'b0, 2'b00);
    chk(d[6:4], 3'h0);
    rd(OFS_SMART_TIME);
    chk(d, 32'h0);
    repeat (3) begin
      op = {2'b01, 6'($urandom)};
      cmd(op, 8'h00, 1'b1, 2'b00);
    end
    xfer(OP_WR_SECT, 16'h0002, 2, 512, 2, 1'b0);
    xfer(OP_WR_NOERASE, 16'h0001, 1, 256, 1, 1'b0);
    wr(OFS_MULTIPLE, 32'h2);
    xfer(OP_WR_MULT, 16'h0003, 3, 768, 2, 1'b0);
    xfer(OP_WR_MULT_EX, 16'h0002, 2, 512, 1, 1'b0);
    xfer(OP_WR_VERIFY, 16'h0002, 2, 512, 2, 1'b0);
    fail <= 1'b1;
    xfer(OP_WR_VERIFY, 16'h0001, 1, 256, 1, 1'b1);
    fail <= 1'b0;
    slow <= 1'b1;
    xfer(OP_WR_DMA_A, 16'h0002, 0, 512, 1, 1'b0);
    slow <= 1'b0;
    xfer(OP_WR_DMA_B, 16'h0101, 0, 256, 1, 1'b0);
    xfer(OP_WR_DMA_EXT, 16'h0003, 0, 768, 1, 1'b0);
    xfer(OP_WR_SECT_EX, 16'h0101, 257, 65792, 257, 1'b0);
    xfer(OP_WR_BUFFER, 16'h0000, 1, 0, 1, 1'b0);
    wr(OFS_BUF_INDEX, 32'h5);
    rd(OFS_BUF_DATA);
    chk(d[15:0], pat(5));
    cmd(OP_SLEEP_A, 8'h00, 1'b0, 2'b10);
    cmd(OP_STANDBY, 8'h00, 1'b0, 2'b01);
    cmd(OP_SLEEP_B, 8'h00, 1'b0, 2'b10);
    cmd(OP_STANDBY_IM, 8'h00, 1'b0, 2'b01);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_COMMAND, {24'h0, OP_WR_SECT_EX});
    chk({31'h0, o_drq}, 32'h1);
    print_verdict();
  end
endmodule : awps_top_bench
